// file: design/csc_cap_sense.sv
`timescale 1ns/100ps
module csc_cap_sense #(
  parameter int ACC_W = 24
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire csc_pkg::csc_cfg_s i_cfg,
  input wire csc_pkg::csc_mon_s i_mon_en,
  input wire csc_pkg::csc_mon_s i_mon_activity,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_flag_clr,
  input wire logic i_done_irq_enable,
  input wire logic i_thr_irq_enable,
  input wire logic [csc_pkg::RES_W-1:0] i_threshold,
  input wire logic i_compare,
  output logic o_sense_busy_start,
  output logic o_done_flag,
  output logic o_thr_flag,
  output logic o_monitor_event_flag,
  output logic o_irq,
  output logic o_shutdown,
  output logic [csc_pkg::CH_W-1:0] o_chan,
  output logic [csc_pkg::RES_W-1:0] o_trial,
  output logic [ACC_W-1:0] o_result
);
  csc_pkg::csc_state_e state_q;
  csc_pkg::csc_mon_s mon_en_q;
  logic busy_q;
  logic done_q;
  logic thr_q;
  logic pme_q;
  logic [csc_pkg::RES_W-1:0] sar_q;
  logic [4:0] bit_q;
  logic [2:0] retry_q;
  // Seven bits so that a set of 64 conversions can be counted
  logic [6:0] acc_cnt_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] result_q;
  logic [csc_pkg::CH_W-1:0] chan_q;

  wire active = i_cfg.enable;
  wire [4:0] low_bit = (i_cfg.conv_length_sel == csc_pkg::LEN_12) ? 5'h4 :
                       (i_cfg.conv_length_sel == csc_pkg::LEN_13) ? 5'h3 :
                       (i_cfg.conv_length_sel == csc_pkg::LEN_14) ? 5'h2 : 5'h0;
  wire [6:0] acc_total = 7'h1 << {i_cfg.acc_sel, 1'b0};
  // Registered enables give monitoring a known off state out of reset
  wire mon_hit = |(mon_en_q & i_mon_activity);
  wire cap_two = (i_cfg.retry_limit_sel == csc_pkg::RETRY_TWO);
  wire cap_four = (i_cfg.retry_limit_sel == csc_pkg::RETRY_FOUR);
  wire retry_ok = (i_cfg.retry_limit_sel == csc_pkg::RETRY_ALL) ||
                  (cap_two && retry_q < csc_pkg::RETRY_CAP_TWO) ||
                  (cap_four && retry_q < csc_pkg::RETRY_CAP_FOUR);
  wire do_retry = (state_q == csc_pkg::CSC_STEP) && mon_hit && retry_ok;
  wire [csc_pkg::RES_W-1:0] bit_mask = csc_pkg::RES_W'(1) << bit_q;
  wire [csc_pkg::RES_W-1:0] trial = sar_q | bit_mask;
  wire [csc_pkg::RES_W-1:0] sar_next = i_compare ? trial : sar_q;
  wire last_bit = (bit_q == low_bit);
  wire conv_end = (state_q == csc_pkg::CSC_STEP) && !do_retry && last_bit;
  wire [ACC_W-1:0] acc_sum = acc_q + ACC_W'(sar_next);
  wire set_last = conv_end && (acc_cnt_q + 7'h1 == acc_total);
  // Plain shift average; the set size is always a power of four
  wire [ACC_W-1:0] avg = acc_sum >> {i_cfg.acc_sel, 1'b0};
  wire crossed = i_cfg.thr_above ? (avg[csc_pkg::RES_W-1:0] > i_threshold)
                                 : (avg[csc_pkg::RES_W-1:0] < i_threshold);
  wire last_chan = !i_cfg.scan_en || chan_q == i_cfg.scan_end;
  wire go_again = i_cfg.continuous || !last_chan;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon_en_q <= '0;
    end else begin
      mon_en_q <= i_mon_en;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= csc_pkg::CSC_IDLE;
      busy_q <= 1'b0;
      sar_q <= '0;
      bit_q <= '0;
      retry_q <= '0;
      acc_cnt_q <= '0;
      acc_q <= '0;
      result_q <= '0;
      chan_q <= '0;
    end else if (!active || i_stop) begin
      state_q <= csc_pkg::CSC_IDLE;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        csc_pkg::CSC_IDLE: begin
          // Start while busy is refused: only the idle state looks at it
          if (i_start) begin
            busy_q <= 1'b1;
            chan_q <= i_cfg.chan;
            state_q <= csc_pkg::CSC_NEXT;
            acc_cnt_q <= '0;
            acc_q <= '0;
          end
        end
        csc_pkg::CSC_NEXT: begin
          // Unresolved low bits keep this zero
          sar_q <= '0;
          bit_q <= 5'(csc_pkg::RES_W - 1);
          retry_q <= '0;
          state_q <= csc_pkg::CSC_STEP;
        end
        csc_pkg::CSC_STEP: begin
          if (do_retry) begin
            // Step is held and tried again; the count may wrap when unlimited
            retry_q <= retry_q + 3'h1;
          end else if (!last_bit) begin
            sar_q <= sar_next;
            bit_q <= bit_q - 5'h1;
          end else if (!set_last) begin
            acc_q <= acc_sum;
            acc_cnt_q <= acc_cnt_q + 7'h1;
            state_q <= csc_pkg::CSC_NEXT;
          end else begin
            result_q <= avg;
            acc_q <= '0;
            acc_cnt_q <= '0;
            if (go_again) begin
              state_q <= csc_pkg::CSC_NEXT;
              if (i_cfg.scan_en) begin
                chan_q <= last_chan ? i_cfg.chan : chan_q + 3'h1;
              end
            end else begin
              state_q <= csc_pkg::CSC_IDLE;
              busy_q <= 1'b0;
            end
          end
        end
        default: state_q <= csc_pkg::CSC_IDLE;
      endcase
    end
  end

  // Set beats clear so no event is lost
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_q <= 1'b0;
      thr_q <= 1'b0;
      pme_q <= 1'b0;
    end else begin
      done_q <= set_last || (done_q && !i_flag_clr);
      thr_q <= (set_last && crossed) || (thr_q && !i_flag_clr);
      pme_q <= do_retry || (pme_q && !i_flag_clr);
    end
  end

  assign o_sense_busy_start = busy_q;
  assign o_done_flag = done_q;
  assign o_thr_flag = thr_q;
  assign o_monitor_event_flag = pme_q;
  assign o_irq = (done_q && i_done_irq_enable) || (thr_q && i_thr_irq_enable);
  assign o_shutdown = !active;
  assign o_chan = chan_q;
  assign o_trial = trial;
  assign o_result = result_q;

  a_done_gate: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_irq && !i_thr_irq_enable) |-> (done_q && i_done_irq_enable))
    else $error("irq without enable");
  a_off_idle: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !active |=> state_q == csc_pkg::CSC_IDLE && !busy_q)
    else $error("active while disabled");
  a_retry_flag: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    do_retry |=> pme_q)
    else $error("retry not flagged");
  a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (pme_q && !i_flag_clr) |=> pme_q)
    else $error("event flag dropped");
  a_retry_cap: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_cfg.retry_limit_sel == csc_pkg::RETRY_TWO && retry_q >= 3'h2) |-> !do_retry)
    else $error("retry cap exceeded");
  a_retry_four: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_cfg.retry_limit_sel == csc_pkg::RETRY_FOUR && retry_q >= 3'h4) |-> !do_retry)
    else $error("retry cap four exceeded");
  a_low_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_cfg.conv_length_sel == csc_pkg::LEN_12 && acc_total == 7'h1 && set_last)
    |=> result_q[3:0] == 4'h0)
    else $error("low bits not zero");
  a_single_end: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (set_last && !go_again && active && !i_stop) |=> !busy_q && done_q)
    else $error("busy not cleared");
  a_msb_first: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == csc_pkg::CSC_NEXT && active && !i_stop) |=> bit_q == 5'hF)
    else $error("not msb first");
  a_start_busy: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == csc_pkg::CSC_IDLE && i_start && active && !i_stop) |=> busy_q)
    else $error("start did not set busy");
  a_cont_repeat: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (set_last && i_cfg.continuous && active && !i_stop)
    |=> busy_q && state_q == csc_pkg::CSC_NEXT)
    else $error("continuous mode stopped");
  a_done_last: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (conv_end && !set_last && !done_q) |=> !done_q)
    else $error("done before last conversion");
  a_thr_set: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (set_last && crossed) |=> thr_q)
    else $error("threshold crossing missed");
  a_retry_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (do_retry && active && !i_stop) |=> sar_q == $past(sar_q) && bit_q == $past(bit_q))
    else $error("retry moved the step");
  a_scan_step: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (set_last && i_cfg.scan_en && !last_chan && active && !i_stop)
    |=> chan_q == $past(chan_q) + 3'h1)
    else $error("scan did not advance");
  a_scan_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (set_last && i_cfg.scan_en && last_chan && go_again && active && !i_stop)
    |=> chan_q == $past(i_cfg.chan))
    else $error("scan did not wrap");
  a_mon_reset: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> mon_en_q == '0)
    else $error("monitor enable not cleared");
endmodule

// file: design/csc_pkg.sv
package csc_pkg;
  localparam int RES_W = 16;
  localparam int CH_W = 3;
  localparam logic [1:0] LEN_12 = 2'h0;
  localparam logic [1:0] LEN_13 = 2'h1;
  localparam logic [1:0] LEN_14 = 2'h2;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [1:0] LEN_RESET = LEN_13;
  localparam logic [1:0] RETRY_ALL = 2'h0;
  localparam logic [1:0] RETRY_TWO = 2'h1;
  localparam logic [1:0] RETRY_FOUR = 2'h2;
  localparam logic [2:0] RETRY_CAP_TWO = 3'h2;
  localparam logic [2:0] RETRY_CAP_FOUR = 3'h4;
  localparam logic [1:0] ACC_RESET = 2'h0;
  typedef enum logic [1:0] {CSC_IDLE, CSC_STEP, CSC_NEXT} csc_state_e;
  typedef struct packed {
    logic twowire_monitor_en;
    logic port_write_monitor_en;
    logic serial_bus_monitor_en;
  } csc_mon_s;
  typedef struct packed {
    logic enable;
    logic continuous;
    logic scan_en;
    logic [2:0] chan;
    logic [2:0] scan_end;
    logic [1:0] conv_length_sel;
    logic [1:0] acc_sel;
    logic [1:0] retry_limit_sel;
    logic thr_above;
  } csc_cfg_s;
endpackage

// file: test/csc_electrode_model.sv
`timescale 1ns/100ps
module csc_electrode_model (
  input wire logic [csc_pkg::RES_W-1:0] i_trial,
  input wire logic [csc_pkg::RES_W-1:0] i_cap,
  output logic o_compare
);
  // Trips while the trial word is at or below the charge
  assign o_compare = (i_trial <= i_cap);
endmodule

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, noise = 1'b0;
  csc_pkg::csc_cfg_s cfg = '0;
  csc_pkg::csc_mon_s mon_en = '0, mon_act = '0;
  logic start = 1'b0, stop = 1'b0, clr = 1'b0, dirq = 1'b0, tirq = 1'b0, cmp;
  logic [15:0] thr = 16'h0000, cap = 16'h0000, trial;
  logic busy, done, thr_f, ev, irq, shut;
  logic [2:0] chan;
  logic [23:0] res;
  int n_mismatch = 0, num_checks = 0;
  always #4 clk = ~clk;
  csc_cap_sense dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_cfg(cfg), .i_mon_en(mon_en),
    .i_mon_activity(mon_act), .i_start(start), .i_stop(stop), .i_flag_clr(clr),
    .i_done_irq_enable(dirq), .i_thr_irq_enable(tirq), .i_threshold(thr), .i_compare(cmp),
    .o_sense_busy_start(busy), .o_done_flag(done), .o_thr_flag(thr_f),
    .o_monitor_event_flag(ev), .o_irq(irq), .o_shutdown(shut), .o_chan(chan),
    .o_trial(trial), .o_result(res));
  csc_electrode_model pad (.i_trial(trial), .i_cap(cap), .o_compare(cmp));
  // Random output switching on monitored sources
  always @(posedge clk) mon_act <= noise ? 3'($urandom) : 3'h0;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] exp_res(input logic [15:0] v, input logic [1:0] len);
    int bits;
    bits = (len == csc_pkg::LEN_16) ? 16 : 12 + len;
    return {8'h00, v & (16'hFFFF << (16 - bits))};
  endfunction
  function automatic logic exp_thr(input logic [23:0] r, input logic [15:0] t, input logic up);
    return up ? (r[15:0] > t) : (r[15:0] < t);
  endfunction
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run(input logic [1:0] len, input logic [1:0] acc, input logic [15:0] v);
    int k;
    @(posedge clk);
    cfg.conv_length_sel <= len;
    cfg.acc_sel <= acc;
    cap <= v;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // Poll only after a spare cycle behind the start
    @(posedge clk);
    @(negedge clk);
    if (cfg.enable) check(busy, 1'b1);
    for (k = 0; k < (cfg.enable ? 3000 : 20) && done !== 1'b1; k++) @(negedge clk);
    if (cfg.enable) check(done, 1'b1);
  endtask
  initial begin
    int i;
    logic [15:0] v;
    logic [23:0] e;
    logic t;
    void'($urandom(20133));
    repeat (10) @(posedge clk);
    check({shut, busy, done, ev}, 4'h8);
    rst_n <= 1'b1;
    cfg.thr_above <= 1'b1;
    run(csc_pkg::LEN_13, 2'h0, 16'h5A5A);
    check({shut, busy, done}, 3'h4);
    @(posedge clk);
    cfg.enable <= 1'b1;
    for (i = 0; i < 12; i++) begin
      v = 16'($urandom);
      @(posedge clk);
      dirq <= i[0];
      tirq <= i[1];
      cfg.chan <= 3'($urandom);
      cfg.thr_above <= i[2];
      thr <= (i < 2) ? 16'h0000 : 16'($urandom);
      run(2'(i % 4), 2'(i % 3), v);
      e = exp_res(v, 2'(i % 4));
      t = exp_thr(e, thr, i[2]);
      check(res, e);
      check({busy, done}, 2'h1);
      check(thr_f, t);
      check(irq, i[0] | (i[1] & t));
    end
    @(posedge clk);
    mon_en.port_write_monitor_en <= 1'b1;
    noise <= 1'b1;
    for (i = 0; i < 3; i++) begin
      v = 16'($urandom);
      @(posedge clk);
      cfg.retry_limit_sel <= 2'(i);
      run(csc_pkg::LEN_16, 2'h0, v);
      check({done, ev}, 2'h3);
      check(res, exp_res(v, csc_pkg::LEN_16));
    end
    @(posedge clk);
    noise <= 1'b0;
    run(csc_pkg::LEN_12, 2'h0, 16'h1234);
    check(ev, 1'b0);
    @(posedge clk);
    cfg.scan_en <= 1'b1;
    cfg.chan <= 3'h2;
    cfg.scan_end <= 3'h4;
    run(csc_pkg::LEN_12, 2'h0, 16'h0F0F);
    check(chan, 3'h3);
    for (i = 0; i < 500 && busy === 1'b1; i++) @(negedge clk);
    check({busy, chan}, 4'h4);
    check(res, exp_res(16'h0F0F, csc_pkg::LEN_12));
    @(posedge clk);
    cfg.scan_en <= 1'b0;
    cfg.continuous <= 1'b1;
    run(csc_pkg::LEN_12, 2'h0, 16'h0F0F);
    repeat (40) @(negedge clk);
    check(busy, 1'b1);
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    repeat (3) @(negedge clk);
    check(busy, 1'b0);
    report_and_stop();
  end
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
